// *** hdl/backlight_pwm.sv ***
`timescale 1ns/1ns
module backlight_pwm (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_tick,
  input  wire logic [7:0] i_duty,
  output logic            o_pwm
);

  logic [7:0] cnt_ff;

  // Period of 255 ticks so duty ff stays high all the time
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cnt_ff <= 8'h00;
    end else if (i_tick) begin
      cnt_ff <= (cnt_ff == 8'hfe) ? 8'h00 : cnt_ff + 8'h01;
    end
  end

  // Output stage
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_pwm <= 1'b1;
    end else begin
      o_pwm <= (cnt_ff < i_duty);
    end
  end

endmodule

// *** hdl/oe_pulse_gen.sv ***
`timescale 1ns/1ns
module oe_pulse_gen #(
  parameter int CNT_W = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_unit_tick,
  input  wire logic             i_start,
  input  wire logic [CNT_W-1:0] i_units,
  output logic                  o_pulse
);

  logic [CNT_W-1:0] cnt_ff;

  // Holds the pulse for i_units unit ticks
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cnt_ff  <= '0;
      o_pulse <= 1'b0;
    end else if (i_start) begin
      cnt_ff  <= i_units;
      o_pulse <= (i_units != '0);
    end else if (i_unit_tick && o_pulse) begin
      cnt_ff  <= cnt_ff - 1'b1;
      o_pulse <= (cnt_ff != {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

endmodule

// *** hdl/panel_ctrl_map.svh ***
`ifndef PANEL_CTRL_MAP_SVH
`define PANEL_CTRL_MAP_SVH
// Register offsets
`define ADDR_FLIP        8'h90
`define ADDR_DRIVE       8'h93
`define ADDR_SECOND_OE   8'hae
`define ADDR_GATE_MOD_OE 8'haf
`define ADDR_DIM_CTRL    8'hb0
`define ADDR_DIM_DUTY    8'hb1
`define ADDR_VCOM        8'hf0
`define ADDR_HALF        8'hfa
`define ADDR_GAMMA       8'hfd
// Reset values
`define RST_FLIP         8'hff
`define RST_DRIVE        8'hff
`define RST_SECOND_OE    7'h54
`define RST_GATE_MOD_OE  8'h70
`define RST_DIM_CTRL     8'h00
`define RST_DIM_DUTY     8'hff
`define RST_VCOM         8'hc8
`define RST_HALF         5'h0a
`define RST_GAMMA        8'h0f
// Field positions
`define FLIP_BIT         1
`define STAGGERED_DRIVE_SELECT_BIT       6
`define STAGGERED_LAYOUT_TYPE_BIT        5
`define FORCE_BIT        2
`define UPPER_MSB        4
`define LOWER_LSB        5
// Code limits and voltage steps in mV
`define SECOND_OE_MIN    7'h02
`define HALF_SAT         5'h15
`define LOWER_SAT        3'h6
`define VCOM_BASE_MV     12'h5dc
`define VCOM_STEP_MV     12'h00a
`define HALF_BASE_MV     13'h0d7a
`define HALF_STEP_MV     13'h004b
`define UPPER_BASE_MV    14'h1a2c
`define LOWER_BASE_MV    10'h0c8
`define REF_STEP_MV      14'h0064
// Backlight duty limits, ff is 100 %
`define DUTY_FULL        8'hff
`define UI_FLOOR         8'he6
`define STILL_FLOOR      8'h99
`define STILL_CEIL       8'he6
`define MOVE_FLOOR       8'h40
`define MOVE_CEIL        8'hb2
// Timing
`define UI_PER_UNIT      12
`define PANEL_LINES      1920
`endif

// *** hdl/panel_ctrl_pkg.sv ***
package panel_ctrl_pkg;

  // One register access from either host link
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    DIM_OFF, DIM_UI, DIM_STILL, DIM_MOVING
  } dim_mode_t;

  typedef enum logic [1:0] {
    DRV_COLUMN, DRV_STAG0, DRV_STAG1
  } drive_mode_t;

  // Analog selections expressed in mV
  typedef struct packed {
    logic [11:0] vcom_mv;
    logic [12:0] half_mv;
    logic [13:0] upper_mv;
    logic [9:0]  lower_mv;
  } volt_sel_t;

endpackage

// *** hdl/panel_timing_voltage_backlight_ctrl.sv ***
`timescale 1ns/1ns
`include "panel_ctrl_map.svh"
// Contract
// - Second OE width code 7 bits, 2n x 12UI, codes 0,1 unsupported, reset 54h.
// - Gate modulation OE width code 8 bits, n x 12UI, reset 70h.
// - Common electrode code 8 bits, 1.50 V plus 10 mV per code, reset C8h.
// - Half supply code 5 bits, 3.45 V plus 75 mV, saturates from 15h.
// - Upper ref 6.7 V plus 100 mV; lower 0.2 V plus 100 mV, saturates 0.8 V.
// - Upper ref in bits 4..0, lower ref in bits 7..5, reset 0Fh.
// - Backlight PWM output derived from content adaptive algorithm.
// - Four dimming modes chosen by register and pin: off, UI, still, moving.
// - Off mode keeps plain gamma; without forced duty PWM is 100 %.
// - UI mode keeps quality, reduction at most 10 %.
// - Still mode estimates duty per image, reduction between 10 and 40 %.
// - Moving mode aims for largest reduction, above 30 %.
// - Staggered bit 0 gives column drive; at 1 layout bit picks type.
// - Vertical flip 1 scans gate lines from last line down to first.
// - Each register one byte, read/write, same address on both links.
// - Staggered drive and layout type both reset to 1.
module panel_timing_voltage_backlight_ctrl #(
  parameter int CLK_PER_UNIT = `UI_PER_UNIT,
  parameter int PWM_DIV      = 4,
  parameter int LINES        = `PANEL_LINES
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst_n,
  input  wire panel_ctrl_pkg::reg_req_t  i_dsi_req,
  input  wire panel_ctrl_pkg::reg_req_t  i_i2c_req,
  output logic [7:0]                     o_reg_rdata,
  output logic                           o_reg_rvalid,
  input  wire logic                      i_dim_pin_en,
  input  wire logic                      i_frame_start,
  input  wire logic                      i_line_start,
  input  wire logic                      i_pix_valid,
  input  wire logic [7:0]                i_pix_luma,
  output logic                           o_second_oe,
  output logic                           o_gate_mod_oe,
  output logic [7:0]                     o_second_oe_units,
  output panel_ctrl_pkg::volt_sel_t      o_volt,
  output panel_ctrl_pkg::drive_mode_t    o_drive_mode,
  output logic                           o_vertical_flip,
  output logic [10:0]                    o_gate_line,
  output panel_ctrl_pkg::dim_mode_t      o_dim_mode,
  output logic                           o_gamma_adjust,
  output logic [7:0]                     o_backlight_duty,
  output logic                           o_backlight_pwm_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  localparam int NREG = 9;

  logic [6:0]                second_oe_pulse_width_ff;
  logic [7:0]                gate_mod_oe_width_ff;
  logic [7:0]                common_electrode_code_ff;
  logic [4:0]                half_supply_code_ff;
  logic [7:0]                gamma_ref_ff;
  logic [7:0]                flip_reg_ff;
  logic [7:0]                drive_reg_ff;
  logic [7:0]                dim_ctrl_ff;
  logic [7:0]                dim_duty_ff;
  panel_ctrl_pkg::reg_req_t  req;
  logic [NREG-1:0]           hit;
  logic [7:0]                nxt_rdata;

  // Maps an offset to a one-hot register select
  function automatic logic [NREG-1:0] reg_sel(input logic [7:0] addr);
    logic [NREG-1:0] s;
    s = '0;
    if (addr == `ADDR_SECOND_OE) begin
      s[0] = 1'b1;
    end else if (addr == `ADDR_GATE_MOD_OE) begin
      s[1] = 1'b1;
    end else if (addr == `ADDR_VCOM) begin
      s[2] = 1'b1;
    end else if (addr == `ADDR_HALF) begin
      s[3] = 1'b1;
    end else if (addr == `ADDR_GAMMA) begin
      s[4] = 1'b1;
    end else if (addr == `ADDR_FLIP) begin
      s[5] = 1'b1;
    end else if (addr == `ADDR_DRIVE) begin
      s[6] = 1'b1;
    end else if (addr == `ADDR_DIM_CTRL) begin
      s[7] = 1'b1;
    end else if (addr == `ADDR_DIM_DUTY) begin
      s[8] = 1'b1;
    end
    return s;
  endfunction

  // Serial link wins when both links access in one cycle
  always_comb begin
    req = (i_dsi_req.wr || i_dsi_req.rd) ? i_dsi_req : i_i2c_req;
    hit = reg_sel(req.addr);
  end

  // Timing registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      second_oe_pulse_width_ff <= `RST_SECOND_OE;
      gate_mod_oe_width_ff     <= `RST_GATE_MOD_OE;
    end else if (req.wr) begin
      // Unsupported codes 00h and 01h are dropped
      if (hit[0] && (req.wdata[6:0] >= `SECOND_OE_MIN)) begin
        second_oe_pulse_width_ff <= req.wdata[6:0];
      end
      if (hit[1]) begin
        gate_mod_oe_width_ff <= req.wdata;
      end
    end
  end

  // Voltage selection registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      common_electrode_code_ff <= `RST_VCOM;
      half_supply_code_ff      <= `RST_HALF;
      gamma_ref_ff             <= `RST_GAMMA;
    end else if (req.wr) begin
      if (hit[2]) begin
        common_electrode_code_ff <= req.wdata;
      end
      if (hit[3]) begin
        half_supply_code_ff <= req.wdata[4:0];
      end
      if (hit[4]) begin
        gamma_ref_ff <= req.wdata;
      end
    end
  end

  // Panel drive and dimming registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      flip_reg_ff  <= `RST_FLIP;
      drive_reg_ff <= `RST_DRIVE;
      dim_ctrl_ff  <= `RST_DIM_CTRL;
      dim_duty_ff  <= `RST_DIM_DUTY;
    end else if (req.wr) begin
      if (hit[5]) begin
        flip_reg_ff <= req.wdata;
      end
      if (hit[6]) begin
        drive_reg_ff <= req.wdata;
      end
      if (hit[7]) begin
        dim_ctrl_ff <= {5'h00, req.wdata[2:0]};
      end
      if (hit[8]) begin
        dim_duty_ff <= req.wdata;
      end
    end
  end

  // Read data, unmapped offsets read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (hit[0]) begin
      nxt_rdata = {1'b0, second_oe_pulse_width_ff};
    end else if (hit[1]) begin
      nxt_rdata = gate_mod_oe_width_ff;
    end else if (hit[2]) begin
      nxt_rdata = common_electrode_code_ff;
    end else if (hit[3]) begin
      nxt_rdata = {3'h0, half_supply_code_ff};
    end else if (hit[4]) begin
      nxt_rdata = gamma_ref_ff;
    end else if (hit[5]) begin
      nxt_rdata = flip_reg_ff;
    end else if (hit[6]) begin
      nxt_rdata = drive_reg_ff;
    end else if (hit[7]) begin
      nxt_rdata = dim_ctrl_ff;
    end else if (hit[8]) begin
      nxt_rdata = dim_duty_ff;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= req.rd && !req.wr;
      if (req.rd && !req.wr) begin
        o_reg_rdata <= nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output enable pulses in units of 12 UI

  logic [15:0] unit_div_ff;
  logic        unit_tick;
  logic [7:0]  oe_units [2];

  assign unit_tick = (unit_div_ff == 16'(CLK_PER_UNIT - 1));

  // Unit tick divider
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_line_start || unit_tick) begin
      unit_div_ff <= 16'h0000;
    end else begin
      unit_div_ff <= unit_div_ff + 16'h0001;
    end
  end

  // Second OE is twice the code, modulation OE is the code
  always_comb begin
    oe_units[0] = {second_oe_pulse_width_ff, 1'b0};
    oe_units[1] = gate_mod_oe_width_ff;
  end

  // Width reported for the second output enable
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_second_oe_units <= 8'h00;
    end else begin
      o_second_oe_units <= oe_units[0];
    end
  end

  logic [1:0] oe_pulse;

  // One pulse generator per output enable
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_oe
      oe_pulse_gen #(
        .CNT_W (8)
      ) u_oe (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_unit_tick (unit_tick),
        .i_start     (i_line_start),
        .i_units     (oe_units[g]),
        .o_pulse     (oe_pulse[g])
      );
    end
  endgenerate

  assign o_second_oe   = oe_pulse[0];
  assign o_gate_mod_oe = oe_pulse[1];

  ////////////////////////////////////////////////////////////////////////////
  // Voltage selections in mV

  // Saturates a code at a ceiling
  function automatic logic [4:0] sat5(input logic [4:0] c,
                                      input logic [4:0] lim);
    return (c > lim) ? lim : c;
  endfunction

  logic [4:0] half_eff;
  logic [4:0] lower_eff;

  always_comb begin
    half_eff  = sat5(half_supply_code_ff, `HALF_SAT);
    lower_eff = sat5({2'b00, gamma_ref_ff[7:`LOWER_LSB]},
                     {2'b00, `LOWER_SAT});
  end

  // Registered voltage codes
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_volt <= '0;
    end else begin
      o_volt.vcom_mv  <= `VCOM_BASE_MV
                         + 12'(common_electrode_code_ff * `VCOM_STEP_MV);
      o_volt.half_mv  <= `HALF_BASE_MV
                         + 13'(half_eff * `HALF_STEP_MV);
      o_volt.upper_mv <= `UPPER_BASE_MV
                         + 14'(gamma_ref_ff[`UPPER_MSB:0] * `REF_STEP_MV);
      o_volt.lower_mv <= `LOWER_BASE_MV
                         + 10'(lower_eff * `REF_STEP_MV);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Panel drive method and gate scan

  logic        scan_down_ff;
  logic [10:0] last_line;

  assign last_line = 11'(LINES);

  // Drive method from staggered and layout bits
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_drive_mode    <= panel_ctrl_pkg::DRV_STAG1;
      o_vertical_flip <= 1'b1;
    end else begin
      o_vertical_flip <= flip_reg_ff[`FLIP_BIT];
      if (!drive_reg_ff[`STAGGERED_DRIVE_SELECT_BIT]) begin
        o_drive_mode <= panel_ctrl_pkg::DRV_COLUMN;
      end else if (drive_reg_ff[`STAGGERED_LAYOUT_TYPE_BIT]) begin
        o_drive_mode <= panel_ctrl_pkg::DRV_STAG1;
      end else begin
        o_drive_mode <= panel_ctrl_pkg::DRV_STAG0;
      end
    end
  end

  // Gate line counter, direction taken at frame start
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      scan_down_ff <= 1'b1;
      o_gate_line  <= 11'h000;
    end else if (i_frame_start) begin
      scan_down_ff <= flip_reg_ff[`FLIP_BIT];
      o_gate_line  <= flip_reg_ff[`FLIP_BIT] ? last_line
                                             : 11'h001;
    end else if (i_line_start) begin
      if (scan_down_ff && (o_gate_line > 11'h001)) begin
        o_gate_line <= o_gate_line - 11'h001;
      end else if (!scan_down_ff && (o_gate_line < last_line)) begin
        o_gate_line <= o_gate_line + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Content adaptive dimming

  panel_ctrl_pkg::dim_mode_t mode;
  logic [7:0]                peak_ff;
  logic [7:0]                content_duty;
  logic [7:0]                nxt_duty;

  // Clamps a value into a window
  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
    logic [7:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // Pin enables the register mode, otherwise off
  always_comb begin
    mode = i_dim_pin_en ? panel_ctrl_pkg::dim_mode_t'(dim_ctrl_ff[1:0])
                        : panel_ctrl_pkg::DIM_OFF;
  end

  // Frame peak luminance
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_frame_start) begin
      peak_ff <= 8'h00;
    end else if (i_pix_valid && (i_pix_luma > peak_ff)) begin
      peak_ff <= i_pix_luma;
    end
  end

  // Duty from the last frame content per mode
  always_comb begin
    case (mode)
      panel_ctrl_pkg::DIM_UI: begin
        content_duty = clamp8(peak_ff, `UI_FLOOR, `DUTY_FULL);
      end
      panel_ctrl_pkg::DIM_STILL: begin
        content_duty = clamp8(peak_ff, `STILL_FLOOR,
                              `STILL_CEIL);
      end
      panel_ctrl_pkg::DIM_MOVING: begin
        content_duty = clamp8(peak_ff, `MOVE_FLOOR,
                              `MOVE_CEIL);
      end
      default: begin
        content_duty = `DUTY_FULL;
      end
    endcase
    nxt_duty = dim_ctrl_ff[`FORCE_BIT] ? dim_duty_ff : content_duty;
  end

  // Duty and mode change only at frame start
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_backlight_duty <= `DUTY_FULL;
      o_dim_mode       <= panel_ctrl_pkg::DIM_OFF;
      o_gamma_adjust   <= 1'b0;
    end else if (i_frame_start) begin
      o_backlight_duty <= nxt_duty;
      o_dim_mode       <= mode;
      o_gamma_adjust   <= (mode != panel_ctrl_pkg::DIM_OFF);
    end
  end

  logic [15:0] pwm_div_ff;
  logic        pwm_tick;

  assign pwm_tick = (pwm_div_ff == 16'(PWM_DIV - 1));

  // PWM step divider
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || pwm_tick) begin
      pwm_div_ff <= 16'h0000;
    end else begin
      pwm_div_ff <= pwm_div_ff + 16'h0001;
    end
  end

  backlight_pwm u_pwm (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_tick    (pwm_tick),
    .i_duty    (o_backlight_duty),
    .o_pwm     (o_backlight_pwm_out)
  );

endmodule

// *** verification/host_link_model.sv ***
`timescale 1ns/1ns
module host_link_model (
  input  wire logic                i_ref_clk,
  input  wire logic [7:0]          i_rdata,
  input  wire logic                i_rvalid,
  output panel_ctrl_pkg::reg_req_t o_dsi_req,
  output panel_ctrl_pkg::reg_req_t o_i2c_req
);
  // Both links idle from time zero
  initial begin
    o_dsi_req = '0;
    o_i2c_req = '0;
  end

  // One strobe cycle on either link, same map on both
  task automatic acc(input bit i2c, input bit wr, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic v);
    @(negedge i_ref_clk);
    if (i2c) begin
      o_i2c_req = '{wr, !wr, a, d};
    end else begin
      o_dsi_req = '{wr, !wr, a, d};
    end
    @(negedge i_ref_clk);
    q = i_rdata;
    v = i_rvalid;
    // Released link shows inverted address and data, no strobe
    if (i2c) begin
      o_i2c_req = '{1'b0, 1'b0, ~a, ~d};
    end else begin
      o_dsi_req = '{1'b0, 1'b0, ~a, ~d};
    end
  endtask
endmodule

// *** verification/panel_ctrl_chk.sv ***
`timescale 1ns/1ns
module panel_ctrl_chk #(
  parameter int CLK_PER_UNIT = 12,
  parameter int LINES        = 1920
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst_n,
  input  wire panel_ctrl_pkg::reg_req_t  i_dsi_req,
  input  wire panel_ctrl_pkg::reg_req_t  i_i2c_req,
  input  wire logic [7:0]                o_reg_rdata,
  input  wire logic                      o_reg_rvalid,
  input  wire logic                      i_dim_pin_en,
  input  wire logic                      i_frame_start,
  input  wire logic                      i_line_start,
  input  wire logic                      o_second_oe,
  input  wire logic [7:0]                o_second_oe_units,
  input  wire logic                      o_vertical_flip,
  input  wire logic [10:0]               o_gate_line,
  input  wire panel_ctrl_pkg::dim_mode_t o_dim_mode,
  input  wire logic                      o_gamma_adjust
);
  logic        dsi_rd;
  logic        i2c_rd;
  logic [15:0] hi_cnt_ff;

  // Reads that the block must answer; serial link wins a collision
  assign dsi_rd = i_dsi_req.rd && !i_dsi_req.wr;
  assign i2c_rd = i_i2c_req.rd && !i_i2c_req.wr &&
                  !(i_dsi_req.rd || i_dsi_req.wr);

  // Cycles the second OE pulse has stood since the last line start
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_line_start) begin
      hi_cnt_ff <= 16'h0000;
    end else if (o_second_oe) begin
      hi_cnt_ff <= hi_cnt_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_read_answers: assert property ((dsi_rd || i2c_rd) |=> o_reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (o_reg_rvalid |-> $past(dsi_rd || i2c_rd))
    else $error("answer without read");
  a_rdata_held: assert property (!o_reg_rvalid && $past(i_rst_n) |-> $stable(o_reg_rdata))
    else $error("read data moved");
  a_pin_forces_off: assert property (i_frame_start && !i_dim_pin_en |=> o_dim_mode == panel_ctrl_pkg::DIM_OFF)
    else $error("pin low but dimming on");
  a_gamma_mode: assert property (o_gamma_adjust == (o_dim_mode != panel_ctrl_pkg::DIM_OFF))
    else $error("gamma adjust wrong for mode");
  a_scan_start: assert property (i_frame_start |=> o_gate_line == ($past(o_vertical_flip) ? LINES : 1))
    else $error("scan start line wrong");
  a_scan_steps: assert property (i_line_start && !i_frame_start && o_vertical_flip && o_gate_line > 1 |=> o_gate_line == $past(o_gate_line) - 1)
    else $error("flipped scan did not step down");
  a_second_oe_rise: assert property (i_line_start |=> o_second_oe)
    else $error("second OE did not start");
  a_second_oe_len: assert property ($fell(o_second_oe) |-> hi_cnt_ff == o_second_oe_units * CLK_PER_UNIT)
    else $error("second OE length wrong");
endmodule

bind panel_timing_voltage_backlight_ctrl panel_ctrl_chk #(
  .CLK_PER_UNIT(CLK_PER_UNIT),
  .LINES(LINES)
) u_chk (
  .i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n),
  .i_dsi_req(i_dsi_req),
  .i_i2c_req(i_i2c_req),
  .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid),
  .i_dim_pin_en(i_dim_pin_en),
  .i_frame_start(i_frame_start),
  .i_line_start(i_line_start),
  .o_second_oe(o_second_oe),
  .o_second_oe_units(o_second_oe_units),
  .o_vertical_flip(o_vertical_flip),
  .o_gate_line(o_gate_line),
  .o_dim_mode(o_dim_mode),
  .o_gamma_adjust(o_gamma_adjust)
);

// *** verification/panel_timing_voltage_backlight_ctrl_test.sv ***
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); \
    end \
  end
module panel_timing_voltage_backlight_ctrl_test;
  localparam int UNIT = 12;
  localparam int LN   = 8;
  logic                        i_ref_clk;
  logic                        i_rst_n;
  panel_ctrl_pkg::reg_req_t    dsi_req, i2c_req;
  panel_ctrl_pkg::volt_sel_t   volt;
  panel_ctrl_pkg::drive_mode_t drive;
  panel_ctrl_pkg::dim_mode_t   dim_mode;
  logic [7:0]                  rdata, pix_luma, units, duty;
  logic [10:0]                 gate_line;
  logic                        rvalid, dim_pin_en, frame_start, line_start;
  logic                        pix_valid, second_oe, gate_oe, flip;
  logic                        gamma_adj, pwm;
  int                          n_errors, cmp_count, n;
  logic [7:0] reg_addr [10] = '{8'h90, 8'h93, 8'hae, 8'haf, 8'hb0, 8'hb1,
                               8'hf0, 8'hfa, 8'hfd, 8'h55};
  logic [7:0] reg_rst [10] = '{8'hff, 8'hff, 8'h54, 8'h70, 8'h00, 8'hff,
                              8'hc8, 8'h0a, 8'h0f, 8'h00};
  logic [7:0] lo_duty [4] = '{8'hff, 8'he6, 8'h99, 8'h40};
  logic [7:0] hi_duty [4] = '{8'hff, 8'hff, 8'he6, 8'hb2};
  logic [7:0] oe_code [2] = '{8'h02, 8'hff};
  logic [7:0] gm_code [3] = '{8'h00, 8'h01, 8'hff};
  panel_ctrl_pkg::drive_mode_t exp_drv [4] = '{panel_ctrl_pkg::DRV_COLUMN,
    panel_ctrl_pkg::DRV_COLUMN, panel_ctrl_pkg::DRV_STAG0,
    panel_ctrl_pkg::DRV_STAG1};

  panel_timing_voltage_backlight_ctrl #(
    .CLK_PER_UNIT(UNIT),
    .PWM_DIV(4),
    .LINES(LN)
  ) DUT (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_dsi_req(dsi_req),
    .i_i2c_req(i2c_req),
    .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid),
    .i_dim_pin_en(dim_pin_en),
    .i_frame_start(frame_start),
    .i_line_start(line_start),
    .i_pix_valid(pix_valid),
    .i_pix_luma(pix_luma),
    .o_second_oe(second_oe),
    .o_gate_mod_oe(gate_oe),
    .o_second_oe_units(units),
    .o_volt(volt),
    .o_drive_mode(drive),
    .o_vertical_flip(flip),
    .o_gate_line(gate_line),
    .o_dim_mode(dim_mode),
    .o_gamma_adjust(gamma_adj),
    .o_backlight_duty(duty),
    .o_backlight_pwm_out(pwm)
  );

  host_link_model host (
    .i_ref_clk(i_ref_clk),
    .i_rdata(rdata),
    .i_rvalid(rvalid),
    .o_dsi_req(dsi_req),
    .o_i2c_req(i2c_req)
  );

  // 100 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  ////////////////////////////////////////
  task automatic tick(input int c);
    repeat (c) @(negedge i_ref_clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge i_ref_clk);
    s = 1'b0;
    @(negedge i_ref_clk);
  endtask

  task automatic wr(input bit l, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    host.acc(l, 1'b1, a, d, q, v);
    `CHK(v, 1'b0)
  endtask

  task automatic rd_chk(input bit l, input logic [7:0] a,
                        input logic [7:0] e);
    logic [7:0] q;
    logic       v;
    host.acc(l, 1'b0, a, 8'h00, q, v);
    `CHK(v, 1'b1)
    `CHK(q, e)
  endtask

  // Start a line and count the cycles an OE pulse stands
  task automatic oe_len(input bit g, output int c);
    c = 0;
    line_start = 1'b1;
    @(negedge i_ref_clk);
    line_start = 1'b0;
    while ((g ? gate_oe : second_oe) === 1'b1 && c < 4000) begin
      c++;
      @(negedge i_ref_clk);
    end
  endtask

  task automatic feed(input logic [7:0] v);
    pix_luma = v;
    pix_valid = 1'b1;
    tick(4);
    pix_valid = 1'b0;
  endtask

  // High cycles of the backlight output over one full period
  task automatic pwm_high(output int h);
    h = 0;
    tick(2);
    repeat (1020) begin
      @(negedge i_ref_clk);
      h += int'(pwm === 1'b1);
    end
  endtask

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #500000;
    n_errors++;
    final_report();
  end

  ////////////////////////////////////////
  initial begin
    {dim_pin_en, frame_start, line_start, pix_valid} = 4'h0;
    pix_luma = 8'h00;
    n_errors = 0;
    cmp_count = 0;
    i_rst_n = 1'b0;
    tick(2);
    i_rst_n = 1'b1;
    tick(1);
    // Reset state of outputs and registers
    `CHK(volt, {12'hdac, 13'h1068, 14'h2008, 10'h0c8})
    `CHK(units, 8'ha8)
    `CHK(drive, panel_ctrl_pkg::DRV_STAG1)
    `CHK({flip, duty}, 9'h1ff)
    for (int i = 0; i < 10; i++) begin
      rd_chk(i[0], reg_addr[i], reg_rst[i]);
    end
    // Extreme voltage codes, saturation, written on alternate links
    wr(1, 8'hf0, 8'hff);
    wr(1, 8'hfa, 8'h1f);
    wr(1, 8'hfd, 8'he0);
    tick(1);
    `CHK(volt, {12'hfd2, 13'h13a1, 14'h1a2c, 10'h320})
    wr(0, 8'hf0, 8'h00);
    wr(0, 8'hfa, 8'hf4);
    wr(0, 8'hfd, 8'hbf);
    tick(1);
    `CHK(volt, {12'h5dc, 13'h1356, 14'h2648, 10'h2bc})
    rd_chk(1, 8'hfa, 8'h14);
    rd_chk(1, 8'hfd, 8'hbf);
    // Second OE: codes 0 and 1 refused, others give 2n units
    wr(0, 8'hae, 8'h01);
    rd_chk(1, 8'hae, 8'h54);
    foreach (oe_code[i]) begin
      wr(1, 8'hae, oe_code[i]);
      tick(1);
      `CHK(units, {oe_code[i][6:0], 1'b0})
      oe_len(1'b0, n);
      `CHK(n, 2 * UNIT * oe_code[i][6:0])
    end
    wr(0, 8'hae, 8'h00);
    rd_chk(0, 8'hae, 8'h7f);
    // Gate modulation OE of n units, none at zero
    foreach (gm_code[i]) begin
      wr(0, 8'haf, gm_code[i]);
      tick(1);
      oe_len(1'b1, n);
      `CHK(n, UNIT * gm_code[i])
    end
    // Staggered drive bit and layout bit
    for (int i = 0; i < 4; i++) begin
      wr(i[0], 8'h93, {1'b1, i[1:0], 5'h1f});
      tick(1);
      `CHK(drive, exp_drv[i])
    end
    // Every dimming mode with dark and bright frames
    dim_pin_en = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(m[0], 8'hb0, 8'(m));
      pulse(frame_start);
      feed(8'h00);
      pulse(frame_start);
      `CHK(dim_mode, panel_ctrl_pkg::dim_mode_t'(m))
      `CHK(gamma_adj, 1'(m != 0))
      `CHK(duty, lo_duty[m])
      feed(8'hff);
      pulse(frame_start);
      `CHK(duty, hi_duty[m])
    end
    // Pin low gives off mode and a full-duty output
    dim_pin_en = 1'b0;
    pulse(frame_start);
    `CHK(dim_mode, panel_ctrl_pkg::DIM_OFF)
    pwm_high(n);
    `CHK(n, 1020)
    // Forced duty drives the output directly
    wr(0, 8'hb1, 8'h33);
    wr(1, 8'hb0, 8'h07);
    dim_pin_en = 1'b1;
    pulse(frame_start);
    `CHK(duty, 8'h33)
    pwm_high(n);
    `CHK(n, 4 * 8'h33)
    // Scan up from line 1, then flipped from the last line down
    wr(0, 8'h90, 8'hfd);
    tick(1);
    `CHK(flip, 1'b0)
    pulse(frame_start);
    `CHK(gate_line, 11'h001)
    pulse(line_start);
    pulse(line_start);
    `CHK(gate_line, 11'h003)
    wr(1, 8'h90, 8'hff);
    tick(1);
    pulse(frame_start);
    `CHK(gate_line, 11'(LN))
    pulse(line_start);
    `CHK(gate_line, 11'(LN - 1))
    final_report();
  end
endmodule
